// File: expansion_port_pkg.sv
// constants for the expansion bus port block: register map, reset values, mode codes
// assumes a 32-bit ahb-lite slave slot with word-aligned registers
// Notes on behaviour
// - port b carries ad bus during external access
// - port b pull-up needs option and input
// - port c eight bits, per-bit direction
// - port c reset makes all pins input
// - mode field assigns port c address pairs
// - output bits drive latch, latch holds value
// - read gives pin for inputs; writes all latches
// - input to output drives stored latch value
// - bit operations are full byte read-modify-write
// - assigned port c pins output address bits
// - port c pull-up needs option and input
// - port d reset makes all pins input
// - port d pins 0-3 give upper address
// - port d pins 4-5 give read/write strobes
// - port d pin 6 is wait input
// - hold enable: pin 6 request, pin 7 acknowledge
// - refresh enable: pin 7 outputs refresh pulses
// - port b is ad bus for codes 3-9
// - control pins ignore software writes and tests
package expansion_port_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_PORT_B_DATA = 8'h00;
    localparam logic [7:0] OFS_PORT_B_DIR = 8'h04;
    localparam logic [7:0] OFS_PORT_C_DATA = 8'h08;
    localparam logic [7:0] OFS_PORT_C_DIR = 8'h0c;
    localparam logic [7:0] OFS_PORT_D_DATA = 8'h10;
    localparam logic [7:0] OFS_PORT_D_DIR = 8'h14;
    localparam logic [7:0] OFS_PULLUP_OPT = 8'h18;
    localparam logic [7:0] OFS_EXP_MODE = 8'h1c;
    localparam logic [7:0] OFS_WAIT_CTRL_A = 8'h20;
    localparam logic [7:0] OFS_WAIT_CTRL_B = 8'h24;
    localparam logic [7:0] OFS_HOLD_CTRL = 8'h28;
    localparam logic [7:0] OFS_REFRESH_CTRL = 8'h2c;
    // reset values
    localparam logic [7:0] DIR_RESET = 8'hff;
    localparam logic [7:0] LATCH_RESET = 8'h00;
    localparam logic [6:0] PULLUP_RESET = 7'h00;
    localparam logic [3:0] MODE_RESET = 4'h0;
    localparam logic [7:0] WAIT_RESET = 8'h00;
    // field positions in the pull-up option register
    localparam int PU_BIT_B = 4;
    localparam int PU_BIT_C = 5;
    localparam int PU_BIT_D = 6;
    // expansion mode codes
    localparam logic [3:0] MODE_AD_FIRST = 4'h3;
    localparam logic [3:0] MODE_A9 = 4'h4;
    localparam logic [3:0] MODE_A11 = 4'h5;
    localparam logic [3:0] MODE_A13 = 4'h6;
    localparam logic [3:0] MODE_A15 = 4'h7;
    localparam logic [3:0] MODE_A17 = 4'h8;
    localparam logic [3:0] MODE_A19 = 4'h9;
    // wait select pair code meaning external wait pin
    localparam logic [1:0] WAIT_SEL_EXT = 2'h3;
    // ahb-lite
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
endpackage

// File: expansion_port.sv
// expansion bus port pins: three 8-bit ports with register access over ahb-lite
// assumes a bus controller supplies address, ad data and strobes during external accesses
`timescale 1ns/1ps
module expansion_port
    import expansion_port_pkg::*;
(
    // clock and reset
    input wire logic REF_CLK_IN,
    input wire logic RESET_N_IN,
    // ahb-lite slave
    input wire logic HSEL_IN,
    input wire logic [31:0] HADDR_IN,
    input wire logic [1:0] HTRANS_IN,
    input wire logic HWRITE_IN,
    input wire logic [2:0] HSIZE_IN,
    input wire logic [31:0] HWDATA_IN,
    input wire logic HREADY_IN,
    output logic [31:0] HRDATA_OUT,
    output logic HREADYOUT_OUT,
    output logic HRESP_OUT,
    // bus controller side
    input wire logic EXT_ACCESS_IN,
    input wire logic [19:0] EXT_ADDR_IN,
    input wire logic EXT_AD_DRIVE_IN,
    input wire logic [7:0] EXT_AD_WDATA_IN,
    input wire logic EXT_RD_STROBE_N_IN,
    input wire logic EXT_WR_STROBE_N_IN,
    input wire logic HOLD_ACK_IN,
    input wire logic REFRESH_PULSE_IN,
    output logic [7:0] EXT_AD_RDATA_OUT,
    output logic EXT_WAIT_OUT,
    output logic HOLD_REQUEST_OUT,
    // port b pins
    input wire logic [7:0] PORT_B_PIN_IN,
    output logic [7:0] PORT_B_PIN_OUT,
    output logic [7:0] PORT_B_PIN_OE_OUT,
    output logic [7:0] PORT_B_PULLUP_OUT,
    // port c pins
    input wire logic [7:0] PORT_C_PIN_IN,
    output logic [7:0] PORT_C_PIN_OUT,
    output logic [7:0] PORT_C_PIN_OE_OUT,
    output logic [7:0] PORT_C_PULLUP_OUT,
    // port d pins
    input wire logic [7:0] PORT_D_PIN_IN,
    output logic [7:0] PORT_D_PIN_OUT,
    output logic [7:0] PORT_D_PIN_OE_OUT,
    output logic [7:0] PORT_D_PULLUP_OUT
);

    logic [1:0] rst_sync_q;
    logic rst_n;
    logic [7:0] lat_b_q, lat_b_d, dir_b_q, dir_b_d;
    logic [7:0] lat_c_q, lat_c_d, dir_c_q, dir_c_d;
    logic [7:0] lat_d_q, lat_d_d, dir_d_q, dir_d_d;
    logic [6:0] pu_q, pu_d;
    logic [3:0] mode_q, mode_d;
    logic [7:0] wca_q, wca_d, wcb_q, wcb_d;
    logic hold_en_q, hold_en_d, refresh_enable_q, refresh_enable_d;
    logic wr_pend_q, wr_pend_d;
    logic [7:0] wr_addr_q, wr_addr_d;
    logic [31:0] rdata_q, rdata_d;
    logic addr_phase;
    logic ad_mode, strobe_mode, wait_fn, any_ext_wait;
    logic [7:0] c_mask, d_ctl;
    logic [3:0] d_addr_mask;
    logic [7:0] b_out_d, b_oe_d, c_out_d, c_oe_d, d_out_d, d_oe_d;
    logic [7:0] b_pu_d, c_pu_d, d_pu_d;
    logic [7:0] b_out_q, b_oe_q, c_out_q, c_oe_q, d_out_q, d_oe_q;
    logic [7:0] b_pu_q, c_pu_q, d_pu_q, ad_rdata_q;
    logic wait_q, hold_req_q;

    // reset release through two flops
    always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    // mode decode
    always_comb begin
        ad_mode = (mode_q >= MODE_AD_FIRST) && (mode_q <= MODE_A19);
        strobe_mode = ad_mode;
        case (mode_q)
            MODE_A9: c_mask = 8'h03;
            MODE_A11: c_mask = 8'h0f;
            MODE_A13: c_mask = 8'h3f;
            MODE_A15, MODE_A17, MODE_A19: c_mask = 8'hff;
            default: c_mask = 8'h00;
        endcase
        case (mode_q)
            MODE_A17: d_addr_mask = 4'h3;
            MODE_A19: d_addr_mask = 4'hf;
            default: d_addr_mask = 4'h0;
        endcase
        any_ext_wait = 1'b0;
        for (int i = 0; i < 4; i++) begin
            any_ext_wait = any_ext_wait || (wca_q[2*i +: 2] == WAIT_SEL_EXT)
                || (wcb_q[2*i +: 2] == WAIT_SEL_EXT);
        end
        wait_fn = any_ext_wait || dir_d_q[6];
        d_ctl = {hold_en_q || refresh_enable_q, hold_en_q || wait_fn,
                 strobe_mode, strobe_mode, d_addr_mask};
    end

    // register file and ahb-lite slave; writes commit at the end of the data phase
    always_comb begin
        addr_phase = HSEL_IN && HTRANS_IN[1] && HREADY_IN;
        lat_b_d = lat_b_q;
        dir_b_d = dir_b_q;
        lat_c_d = lat_c_q;
        dir_c_d = dir_c_q;
        lat_d_d = lat_d_q;
        dir_d_d = dir_d_q;
        pu_d = pu_q;
        mode_d = mode_q;
        wca_d = wca_q;
        wcb_d = wcb_q;
        hold_en_d = hold_en_q;
        refresh_enable_d = refresh_enable_q;
        wr_pend_d = addr_phase && HWRITE_IN;
        wr_addr_d = HADDR_IN[7:0];
        rdata_d = rdata_q;
        if (wr_pend_q) begin
            case (wr_addr_q)
                // all latches but the port d control pins take the byte whatever the direction
                OFS_PORT_B_DATA: lat_b_d = HWDATA_IN[7:0];
                OFS_PORT_B_DIR: dir_b_d = HWDATA_IN[7:0];
                OFS_PORT_C_DATA: lat_c_d = HWDATA_IN[7:0];
                OFS_PORT_C_DIR: dir_c_d = HWDATA_IN[7:0];
                // control pins keep their latch
                OFS_PORT_D_DATA: lat_d_d = (d_ctl & lat_d_q) | (~d_ctl & HWDATA_IN[7:0]);
                OFS_PORT_D_DIR: dir_d_d = HWDATA_IN[7:0];
                OFS_PULLUP_OPT: pu_d = HWDATA_IN[6:0];
                OFS_EXP_MODE: mode_d = HWDATA_IN[3:0];
                OFS_WAIT_CTRL_A: wca_d = HWDATA_IN[7:0];
                OFS_WAIT_CTRL_B: wcb_d = HWDATA_IN[7:0];
                OFS_HOLD_CTRL: hold_en_d = HWDATA_IN[0];
                OFS_REFRESH_CTRL: refresh_enable_d = HWDATA_IN[0];
                default: ;
            endcase
        end
        if (addr_phase && !HWRITE_IN) begin
            // input bits show the pin, never the latch
            case (HADDR_IN[7:0])
                OFS_PORT_B_DATA: rdata_d = {24'h0, (dir_b_q & PORT_B_PIN_IN) | (~dir_b_q & lat_b_q)};
                OFS_PORT_B_DIR: rdata_d = {24'h0, dir_b_q};
                OFS_PORT_C_DATA: rdata_d = {24'h0, (dir_c_q & PORT_C_PIN_IN) | (~dir_c_q & lat_c_q)};
                OFS_PORT_C_DIR: rdata_d = {24'h0, dir_c_q};
                // control pins read as zero
                OFS_PORT_D_DATA: rdata_d = {24'h0,
                    ~d_ctl & ((dir_d_q & PORT_D_PIN_IN) | (~dir_d_q & lat_d_q))};
                OFS_PORT_D_DIR: rdata_d = {24'h0, dir_d_q};
                OFS_PULLUP_OPT: rdata_d = {25'h0, pu_q};
                OFS_EXP_MODE: rdata_d = {28'h0, mode_q};
                OFS_WAIT_CTRL_A: rdata_d = {24'h0, wca_q};
                OFS_WAIT_CTRL_B: rdata_d = {24'h0, wcb_q};
                OFS_HOLD_CTRL: rdata_d = {31'h0, hold_en_q};
                OFS_REFRESH_CTRL: rdata_d = {31'h0, refresh_enable_q};
                default: rdata_d = 32'h0;
            endcase
        end
    end

    // latches reset to zero only to keep them defined; software must not rely on it
    always_ff @(posedge REF_CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            lat_b_q <= LATCH_RESET;
            dir_b_q <= DIR_RESET;
            lat_c_q <= LATCH_RESET;
            dir_c_q <= DIR_RESET;
            lat_d_q <= LATCH_RESET;
            dir_d_q <= DIR_RESET;
            pu_q <= PULLUP_RESET;
            mode_q <= MODE_RESET;
            wca_q <= WAIT_RESET;
            wcb_q <= WAIT_RESET;
            hold_en_q <= 1'b0;
            refresh_enable_q <= 1'b0;
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
            rdata_q <= 32'h0;
        end else begin
            lat_b_q <= lat_b_d;
            dir_b_q <= dir_b_d;
            lat_c_q <= lat_c_d;
            dir_c_q <= dir_c_d;
            lat_d_q <= lat_d_d;
            dir_d_q <= dir_d_d;
            pu_q <= pu_d;
            mode_q <= mode_d;
            wca_q <= wca_d;
            wcb_q <= wcb_d;
            hold_en_q <= hold_en_d;
            refresh_enable_q <= refresh_enable_d;
            wr_pend_q <= wr_pend_d;
            wr_addr_q <= wr_addr_d;
            rdata_q <= rdata_d;
        end
    end

    // pin drive; one flop stage so every pin output is registered
    always_comb begin
        if (ad_mode) begin
            // ad bus only driven while the controller owns it
            b_oe_d = (EXT_ACCESS_IN && EXT_AD_DRIVE_IN) ? 8'hff : 8'h00;
            b_out_d = EXT_AD_WDATA_IN;
        end else begin
            b_oe_d = ~dir_b_q;
            b_out_d = lat_b_q;
        end
        // address pins driven regardless of direction
        c_out_d = (c_mask & EXT_ADDR_IN[15:8]) | (~c_mask & lat_c_q);
        c_oe_d = c_mask | ~dir_c_q;
        d_out_d[3:0] = (d_addr_mask & EXT_ADDR_IN[19:16]) | (~d_addr_mask & lat_d_q[3:0]);
        d_oe_d[3:0] = d_addr_mask | ~dir_d_q[3:0];
        if (strobe_mode) begin
            d_out_d[5:4] = {EXT_WR_STROBE_N_IN, EXT_RD_STROBE_N_IN};
            d_oe_d[5:4] = 2'h3;
        end else begin
            d_out_d[5:4] = lat_d_q[5:4];
            d_oe_d[5:4] = ~dir_d_q[5:4];
        end
        d_out_d[6] = lat_d_q[6];
        d_oe_d[6] = !(hold_en_q || wait_fn) && !dir_d_q[6];
        // hold acknowledge outranks refresh when both are enabled
        if (hold_en_q) begin
            d_out_d[7] = HOLD_ACK_IN;
            d_oe_d[7] = 1'b1;
        end else if (refresh_enable_q) begin
            d_out_d[7] = REFRESH_PULSE_IN;
            d_oe_d[7] = 1'b1;
        end else begin
            d_out_d[7] = lat_d_q[7];
            d_oe_d[7] = !dir_d_q[7];
        end
        b_pu_d = {8{pu_q[PU_BIT_B]}} & dir_b_q;
        c_pu_d = {8{pu_q[PU_BIT_C]}} & dir_c_q;
        d_pu_d = {8{pu_q[PU_BIT_D]}} & dir_d_q;
    end

    always_ff @(posedge REF_CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            b_out_q <= 8'h00;
            b_oe_q <= 8'h00;
            c_out_q <= 8'h00;
            c_oe_q <= 8'h00;
            d_out_q <= 8'h00;
            d_oe_q <= 8'h00;
            b_pu_q <= 8'h00;
            c_pu_q <= 8'h00;
            d_pu_q <= 8'h00;
            ad_rdata_q <= 8'h00;
            wait_q <= 1'b0;
            hold_req_q <= 1'b0;
        end else begin
            b_out_q <= b_out_d;
            b_oe_q <= b_oe_d;
            c_out_q <= c_out_d;
            c_oe_q <= c_oe_d;
            d_out_q <= d_out_d;
            d_oe_q <= d_oe_d;
            b_pu_q <= b_pu_d;
            c_pu_q <= c_pu_d;
            d_pu_q <= d_pu_d;
            ad_rdata_q <= PORT_B_PIN_IN;
            wait_q <= wait_fn && !hold_en_q && PORT_D_PIN_IN[6];
            hold_req_q <= hold_en_q && PORT_D_PIN_IN[6];
        end
    end

    assign HRDATA_OUT = rdata_q;
    assign HREADYOUT_OUT = rst_n;
    assign HRESP_OUT = 1'b0;
    assign EXT_AD_RDATA_OUT = ad_rdata_q;
    assign EXT_WAIT_OUT = wait_q;
    assign HOLD_REQUEST_OUT = hold_req_q;
    assign PORT_B_PIN_OUT = b_out_q;
    assign PORT_B_PIN_OE_OUT = b_oe_q;
    assign PORT_B_PULLUP_OUT = b_pu_q;
    assign PORT_C_PIN_OUT = c_out_q;
    assign PORT_C_PIN_OE_OUT = c_oe_q;
    assign PORT_C_PULLUP_OUT = c_pu_q;
    assign PORT_D_PIN_OUT = d_out_q;
    assign PORT_D_PIN_OE_OUT = d_oe_q;
    assign PORT_D_PULLUP_OUT = d_pu_q;

    default clocking cb @(posedge REF_CLK_IN); endclocking
    default disable iff (!rst_n);

    sequence s_wr_c_addr;
        addr_phase && HWRITE_IN && (HADDR_IN[7:0] == OFS_PORT_C_DATA);
    endsequence
    sequence s_wr_c;
        s_wr_c_addr ##1 1'b1;
    endsequence

    a_pullup_b_gate: assert property (##1 PORT_B_PULLUP_OUT ==
        ($past(pu_q[PU_BIT_B]) ? $past(dir_b_q) : 8'h00)) else $error("port b pull-up wrong");
    a_pullup_c_gate: assert property (##1 PORT_C_PULLUP_OUT ==
        ($past(pu_q[PU_BIT_C]) ? $past(dir_c_q) : 8'h00)) else $error("port c pull-up wrong");
    a_dir_c_reset: assert property ($rose(rst_n) |-> dir_c_q == 8'hff)
        else $error("port c not input after reset");
    a_ad_drive: assert property (ad_mode && EXT_ACCESS_IN && EXT_AD_DRIVE_IN
        |=> PORT_B_PIN_OE_OUT == 8'hff) else $error("ad bus not driven");
    a_addr_full: assert property ((mode_q == MODE_A15) |=>
        PORT_C_PIN_OE_OUT == 8'hff && PORT_C_PIN_OUT == $past(EXT_ADDR_IN[15:8]))
        else $error("upper address not output");
    a_pair_mode4: assert property ((mode_q == MODE_A9) |=>
        PORT_C_PIN_OE_OUT == {~$past(dir_c_q[7:2]), 2'h3}) else $error("pair assign wrong");
    a_latch_drive: assert property ((mode_q == 4'h0) |=>
        PORT_C_PIN_OE_OUT == ~$past(dir_c_q) && PORT_C_PIN_OUT == $past(lat_c_q))
        else $error("latch not on pin");
    a_latch_write: assert property (s_wr_c |=> lat_c_q == $past(HWDATA_IN[7:0]))
        else $error("latch write lost");
    a_strobe_drive: assert property (strobe_mode |=> PORT_D_PIN_OE_OUT[5:4] == 2'h3)
        else $error("strobes not driven");
    a_refresh_out: assert property (refresh_enable_q && !hold_en_q |=>
        PORT_D_PIN_OUT[7] == $past(REFRESH_PULSE_IN)) else $error("refresh not output");
    a_hold_request: assert property (hold_en_q |=>
        HOLD_REQUEST_OUT == $past(PORT_D_PIN_IN[6]) && !PORT_D_PIN_OE_OUT[6])
        else $error("hold request wrong");
endmodule

// File: ext_bus_device.sv
// far-side model for one 8-bit port: external devices, pads and pull-ups
// assumes the block's pin outputs and a bench-chosen external drive per bit
`timescale 1ns/1ps
module ext_bus_device (
    // clock
    input wire logic clk_in,
    // block side
    input wire logic [7:0] oe_in,
    input wire logic [7:0] drv_in,
    input wire logic [7:0] pu_in,
    // external drive
    input wire logic [7:0] ext_en_in,
    input wire logic [7:0] ext_val_in,
    output logic [7:0] pin_out
);
    logic [7:0] last_q = 8'h00;
    // an undriven, unpulled pad drifts: show the inverse of its last level, never a stale one
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            pin_out[i] = oe_in[i] ? drv_in[i] : ext_en_in[i] ? ext_val_in[i] :
                pu_in[i] ? 1'b1 : ~last_q[i];
        end
    end
    // plain always: the declaration gives the pad a defined start level
    always @(posedge clk_in) begin
        last_q <= pin_out;
    end
endmodule

// File: expansion_port_tb.sv
// self-checking bench for the expansion bus port block
// assumes the block registers its pin outputs; bus latency is polled, never assumed
`timescale 1ns/1ps
module expansion_port_tb;
    import expansion_port_pkg::*;
    logic clk = 0, rst_n = 0, hsel = 0, hwrite = 0, hready, hresp;
    logic [31:0] haddr = 0, hwdata = 0, hrdata;
    logic [1:0] htrans = 0;
    logic ext_acc = 0, ad_drv = 0, rd_n = 1, wr_n = 1, hold_ack = 0, rfsh = 0, wait_o, hreq;
    logic [19:0] ext_addr = 20'h5a5c3;
    logic [7:0] ad_wd = 8'h69, ad_rd;
    logic [7:0] pin [3], pout [3], poe [3], ppu [3];
    logic [7:0] ext_en [3] = '{8'h00, 8'h00, 8'h00};
    logic [7:0] ext_val [3] = '{8'h00, 8'h00, 8'h00};
    int fails = 0, samples_checked = 0;
    logic [7:0] codes [8] = '{8'h0, 8'h3, 8'h4, 8'h5, 8'h6, 8'h7, 8'h8, 8'h9};

    initial begin
        forever #25 clk = ~clk;
    end

    expansion_port expansion_port_inst (.REF_CLK_IN(clk), .RESET_N_IN(rst_n), .HSEL_IN(hsel),
        .HADDR_IN(haddr), .HTRANS_IN(htrans), .HWRITE_IN(hwrite), .HSIZE_IN(3'h2),
        .HWDATA_IN(hwdata), .HREADY_IN(hready), .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hready),
        .HRESP_OUT(hresp), .EXT_ACCESS_IN(ext_acc), .EXT_ADDR_IN(ext_addr),
        .EXT_AD_DRIVE_IN(ad_drv), .EXT_AD_WDATA_IN(ad_wd), .EXT_RD_STROBE_N_IN(rd_n),
        .EXT_WR_STROBE_N_IN(wr_n), .HOLD_ACK_IN(hold_ack), .REFRESH_PULSE_IN(rfsh),
        .EXT_AD_RDATA_OUT(ad_rd), .EXT_WAIT_OUT(wait_o), .HOLD_REQUEST_OUT(hreq),
        .PORT_B_PIN_IN(pin[0]), .PORT_B_PIN_OUT(pout[0]), .PORT_B_PIN_OE_OUT(poe[0]),
        .PORT_B_PULLUP_OUT(ppu[0]), .PORT_C_PIN_IN(pin[1]), .PORT_C_PIN_OUT(pout[1]),
        .PORT_C_PIN_OE_OUT(poe[1]), .PORT_C_PULLUP_OUT(ppu[1]), .PORT_D_PIN_IN(pin[2]),
        .PORT_D_PIN_OUT(pout[2]), .PORT_D_PIN_OE_OUT(poe[2]), .PORT_D_PULLUP_OUT(ppu[2]));

    for (genvar g = 0; g < 3; g++) begin : pad
        ext_bus_device ext_bus_device_inst (.clk_in(clk), .oe_in(poe[g]), .drv_in(pout[g]),
            .pu_in(ppu[g]), .ext_en_in(ext_en[g]), .ext_val_in(ext_val[g]), .pin_out(pin[g]));
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // bus latency is not assumed: poll ready under a bound
    task automatic wait_ready;
        int n;
        n = 0;
        @(posedge clk);
        while (hready !== 1'b1) begin
            n++;
            if (n > 20) begin
                fails++;
                tally_and_finish();
            end
            @(posedge clk);
        end
    endtask

    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                        output logic [31:0] rd);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        haddr <= {24'h0, a};
        hwrite <= wr;
        wait_ready();
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready();
        rd = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] v;
        xfer(1'b1, a, d, v);
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] v;
        xfer(1'b0, a, 32'h0, v);
        chk(v, exp);
    endtask

    task automatic t_reset;
        chk({poe[0], poe[1], poe[2]}, 32'h0);
        chk({ppu[0], ppu[1], ppu[2]}, 32'h0);
        rdchk(OFS_PORT_C_DIR, 32'hff);
        rdchk(OFS_PORT_D_DIR, 32'hff);
        rdchk(OFS_EXP_MODE, 32'h0);
        $display("reset test done");
    endtask

    task automatic t_latch;
        logic [31:0] v;
        @(posedge clk);
        ext_val[1] <= 8'h3c;
        ext_en[1] <= 8'hff;
        wr(OFS_PORT_C_DATA, 32'ha5);
        tick(2);
        chk(poe[1], 8'h00);
        rdchk(OFS_PORT_C_DATA, 32'h3c);
        wr(OFS_PORT_C_DIR, 32'h0f);
        tick(2);
        chk(poe[1], 8'hf0);
        chk(pout[1] & 8'hf0, 8'ha0);
        // a bit clear is a byte read-modify-write, so input latches take the pin levels
        xfer(1'b0, OFS_PORT_C_DATA, 32'h0, v);
        chk(v, 32'hac);
        wr(OFS_PORT_C_DATA, v & 32'h7f);
        wr(OFS_PORT_C_DIR, 32'h00);
        tick(2);
        chk(pout[1], 8'h2c);
        $display("latch test done");
    endtask

    task automatic t_pullup;
        wr(OFS_PORT_B_DIR, 32'hf0);
        wr(OFS_PORT_C_DIR, 32'h33);
        @(posedge clk);
        ext_en[1] <= 8'h00;
        wr(OFS_PULLUP_OPT, 32'h70);
        tick(2);
        chk(ppu[0], 8'hf0);
        chk(ppu[1], 8'h33);
        rdchk(OFS_PORT_C_DATA, 32'h3f);
        wr(OFS_PULLUP_OPT, 32'h10);
        tick(2);
        chk({ppu[0], ppu[1]}, 16'hf000);
        // option cleared before bus use
        wr(OFS_PULLUP_OPT, 32'h00);
        wr(OFS_PORT_B_DIR, 32'hff);
        wr(OFS_PORT_C_DIR, 32'hff);
        tick(2);
        chk(ppu[0], 8'h00);
        $display("pull-up test done");
    endtask

    task automatic t_modes;
        logic [7:0] c, cm, dm;
        @(posedge clk);
        ext_acc <= 1'b1;
        ad_drv <= 1'b1;
        rd_n <= 1'b0;
        foreach (codes[i]) begin
            c = codes[i];
            wr(OFS_EXP_MODE, {28'h0, c[3:0]});
            tick(2);
            cm = c == 4 ? 8'h03 : c == 5 ? 8'h0f : c == 6 ? 8'h3f : c >= 7 ? 8'hff : 8'h00;
            dm = (c == 8 ? 8'h03 : c == 9 ? 8'h0f : 8'h00) | (c >= 3 ? 8'h30 : 8'h00);
            chk(poe[1], cm);
            chk(pout[1] & cm, ext_addr[15:8] & cm);
            chk(poe[2], dm);
            chk(pout[2] & dm, 8'h25 & dm);
            chk(poe[0], c >= 3 ? 8'hff : 8'h00);
            chk(pout[0] & poe[0], c >= 3 ? ad_wd : 8'h00);
        end
        @(posedge clk);
        ad_drv <= 1'b0;
        ext_en[0] <= 8'hff;
        ext_val[0] <= 8'h96;
        tick(3);
        chk(poe[0], 8'h00);
        chk(ad_rd, 8'h96);
        $display("mode test done");
    endtask

    task automatic t_ctrl;
        wr(OFS_PORT_D_DIR, 32'h00);
        wr(OFS_PORT_D_DATA, 32'hff);
        tick(2);
        chk(pout[2] & 8'h3f, 8'h25);
        chk(pout[2][7:6], 2'b11);
        rdchk(OFS_PORT_D_DATA, 32'hc0);
        @(posedge clk);
        ext_en[2] <= 8'h40;
        ext_val[2] <= 8'h40;
        wr(OFS_PORT_D_DIR, 32'h40);
        tick(2);
        chk(wait_o, 1'b1);
        @(posedge clk);
        ext_val[2] <= 8'h00;
        tick(3);
        chk(wait_o, 1'b0);
        wr(OFS_PORT_D_DIR, 32'h00);
        wr(OFS_WAIT_CTRL_B, 32'h0c);
        @(posedge clk);
        ext_val[2] <= 8'h40;
        tick(3);
        chk({poe[2][6], wait_o}, 2'b01);
        wr(OFS_HOLD_CTRL, 32'h1);
        hold_ack <= 1'b1;
        tick(3);
        chk({hreq, poe[2][7], pout[2][7]}, 3'b111);
        @(posedge clk);
        hold_ack <= 1'b0;
        tick(3);
        chk(pout[2][7], 1'b0);
        wr(OFS_HOLD_CTRL, 32'h0);
        wr(OFS_REFRESH_CTRL, 32'h1);
        rfsh <= 1'b1;
        tick(3);
        chk({poe[2][7], pout[2][7]}, 2'b11);
        @(posedge clk);
        rfsh <= 1'b0;
        tick(3);
        chk(pout[2][7], 1'b0);
        rdchk(8'h30, 32'h0);
        wr(8'h30, 32'hffffffff);
        rdchk(8'h30, 32'h0);
        chk(hresp, 1'b0);
        $display("control pin test done");
    endtask

    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        tick(3);
        t_reset();
        t_latch();
        t_pullup();
        t_modes();
        t_ctrl();
        tally_and_finish();
    end
endmodule
